// [rfr_pkg.sv]
// constants, field layout and types for the reading filter and relative block
package rfr_pkg;
   localparam int NF = 6;
   localparam int FW = 3;
   localparam int DW = 24;
   localparam int OW = DW + 1;
   localparam int SW = 31;
   localparam int CW = 7;
   localparam int WW = 10;
   localparam int CHW = 10;
   localparam int NCH = 8;
   localparam int IW = 3;
   localparam int STK = 100;
   localparam int XW = 40;
   localparam int NST = 4;
   typedef enum logic [2:0] {
      RFR_DCV = 3'h0, RFR_DCI = 3'h1, RFR_ACI = 3'h2,
      RFR_RES2 = 3'h3, RFR_RES4 = 3'h4, RFR_TEMP = 3'h5,
      RFR_DCV_Q = 3'h6, RFR_DCI_Q = 3'h7
   } rfr_func_t;
   localparam logic TYPE_BLOCK = 1'b0;
   localparam logic TYPE_SLIDE = 1'b1;
   localparam logic [CW-1:0] CNT_DEF = 7'h0A;
   localparam logic [CW-1:0] CNT_MIN = 7'h01;
   localparam logic [CW-1:0] CNT_MAX = 7'h64;
   localparam logic [WW-1:0] WIN_DEF = 10'h00A;
   localparam logic [WW-1:0] WIN_MAX = 10'h3E8;
   localparam logic [13:0] WIN_SCALE = 14'h2710;
   localparam logic [DW-1:0] TOP_LIMIT = 24'h7A1200;
   localparam int RNG_SHIFT = 3;
   localparam logic [2:0] RNG_TOP = 3'h7;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_FSEL = 8'h04;
   localparam logic [7:0] A_FCFG = 8'h08;
   localparam logic [7:0] A_CHCFG = 8'h0C;
   localparam logic [7:0] A_CHDEF = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [7:0] A_MASK = 8'h18;
   localparam logic [7:0] A_ERR = 8'h1C;
   localparam logic [7:0] A_REF = 8'h20;
   localparam logic [7:0] A_LAST = 8'h24;
   localparam int CT_PRESET = 0;
   localparam int CT_SCAN = 1;
   localparam int FC_TYPE = 0;
   localparam int FC_EN = 1;
   localparam int FC_REL = 2;
   localparam int FC_CNT = 8;
   localparam int FC_WIN = 16;
   localparam int CH_FIRST = 0;
   localparam int CH_LAST = 10;
   localparam int CH_CNT = 20;
   localparam int CH_EN = 27;
   localparam int CH_SETCNT = 28;
   localparam int CH_SETEN = 29;
   localparam int CD_IDX = 0;
   localparam int CD_CODE = 4;
   localparam int CD_FUNC = 14;
   localparam int CD_VALID = 17;
   localparam int ST_RDY = 0;
   localparam int ST_CONF = 1;
   localparam int ST_OVR = 2;
   localparam int ST_PERR = 3;
   localparam logic [31:0] ERR_CONFLICT = 32'hFFFFFF23;
endpackage

// [rfr_filter.sv]
// reading filter, relative offset and apb register file
// Contract
// RULE1: each function holds a filter type, sliding or block averaging.
// RULE2: window is 0 to 10 percent, default 0.1 percent; host keeps range.
// RULE3: window zero disables window checking completely.
// RULE4: filter count is 1 to 100, default 10; host keeps range.
// RULE5: general reset gives block type, preset gives sliding type.
// RULE6: general reset turns filter off, preset turns it on.
// RULE7: channel code is slot 1 to 5 plus two-digit channel; lists and ranges.
// RULE8: channel setting with mismatched function is rejected with error -221.
// RULE9: count and enable may be stored per channel; type and window not.
// RULE10: dc qualifier is optional; both forms reach the same setting.
// RULE11: enabling relative captures present reading; output is input minus it.
// RULE12: one reference per function, used unchanged on every range.
// RULE13: reference may reach full scale of the highest range.
// RULE14: overflow uses raw input against range limit, not the reference.
// RULE15: sliding replaces oldest entry each reading; block averages then clears.
// RULE16: reading outside the window restarts filter seeded with that reading.
// RULE17: while scanning, sliding filter stays off and window is ignored.
// RULE18: function or range change resets filter to that function's setup.
// RULE19: reference subtraction is signed and one bit wider, no wraparound.
`timescale 1ns/100ps
module rfr_filter
   import rfr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic irq,
   input wire logic rd_valid,
   input wire logic signed [DW-1:0] rd_data,
   input wire logic [FW-1:0] rd_func,
   input wire logic [2:0] rd_range,
   input wire logic [CHW-1:0] slot_channel_code,
   output logic out_valid,
   output logic signed [OW-1:0] out_data,
   output logic out_over,
   output logic out_settled
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [FW-1:0] fn_norm(input logic [FW-1:0] f);
      if (f == RFR_DCV_Q)
         return RFR_DCV;
      if (f == RFR_DCI_Q)
         return RFR_DCI;
      return f;
   endfunction
   function automatic logic [DW-1:0] abs_v(input logic signed [DW-1:0] x);
      return DW'(x < 0 ? -x : x);
   endfunction
   function automatic logic [DW-1:0] range_limit(input logic [2:0] rng);
      logic [5:0] sh;
      sh = 6'(RNG_SHIFT * int'(RNG_TOP - rng));
      return TOP_LIMIT >> sh;
   endfunction
   function automatic logic signed [DW-1:0] avg_of(input logic signed [SW-1:0] s,
                                                  input logic [CW-1:0] n);
      logic signed [SW-1:0] q;
      q = (n == '0) ? '0 : s / $signed({{(SW-CW){1'b0}}, n});
      return q[DW-1:0];
   endfunction
   function automatic logic win_out(input logic signed [DW-1:0] x,
                                    input logic signed [DW-1:0] a,
                                    input logic [WW-1:0] w, input logic [DW-1:0] lim);
      logic signed [DW:0] df;
      logic [XW-1:0] l;
      logic [XW-1:0] r;
      df = (DW+1)'(x) - (DW+1)'(a);
      l = XW'(df < 0 ? -df : df) * XW'(WIN_SCALE);
      r = XW'(w) * XW'(lim);
      return l > r;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   logic [NF-1:0] ftype_r, fen_r, rel_en_r, rel_cap_r;
   logic [CW-1:0] fcnt_r [NF];
   logic [WW-1:0] fwin_r [NF];
   logic signed [DW-1:0] ref_r [NF];
   logic [FW-1:0] fsel_r;
   logic scan_r;
   logic [CHW-1:0] ch_code_r [NCH];
   logic [FW-1:0] ch_func_r [NCH];
   logic [CW-1:0] ch_cnt_r [NCH];
   logic [NCH-1:0] ch_en_r, ch_vld_r;
   logic signed [DW-1:0] stk_r [STK];
   logic signed [SW-1:0] sum_r, sum_nxt;
   logic [CW-1:0] fill_r, fill_nxt, wp_r, wp_nxt;
   logic [FW-1:0] last_fn_r;
   logic [2:0] last_rng_r;
   logic [NST-1:0] st_r, mask_r;
   logic [31:0] err_r, rdata_r;
   logic signed [DW-1:0] last_r;
   ////////////////////////////////////////////////////////////////////////////
   // apb decode; data is sampled in setup so read data comes from a flop
   wire wr = psel & penable & pwrite;
   wire setup_rd = psel & ~penable & ~pwrite;
   wire acc_rd = psel & penable & ~pwrite;
   wire hit_ctrl = (paddr == A_CTRL);
   wire hit_fsel = (paddr == A_FSEL);
   wire hit_fcfg = (paddr == A_FCFG);
   wire hit_chcfg = (paddr == A_CHCFG);
   wire hit_chdef = (paddr == A_CHDEF);
   wire hit_stat = (paddr == A_STAT);
   wire hit_mask = (paddr == A_MASK);
   wire hit_err = (paddr == A_ERR);
   wire hit_ref = (paddr == A_REF);
   wire hit_last = (paddr == A_LAST);
   wire mapped = hit_ctrl | hit_fsel | hit_fcfg | hit_chcfg | hit_chdef | hit_stat |
                 hit_mask | hit_err | hit_ref | hit_last;
   wire preset_w = wr & hit_ctrl & pwdata[CT_PRESET];
   wire [FW-1:0] cfg_fn = fn_norm(fsel_r); // RULE10
   wire [CW-1:0] w_cnt = pwdata[FC_CNT +: CW];
   wire [WW-1:0] w_win = pwdata[FC_WIN +: WW];
   wire fcfg_bad = (w_cnt < CNT_MIN) | (w_cnt > CNT_MAX) | (w_win > WIN_MAX); // RULE2 RULE4
   wire fcfg_ok = wr & hit_fcfg & ~fcfg_bad;
   wire [CW-1:0] c_cnt = pwdata[CH_CNT +: CW];
   wire [CHW-1:0] c_first = pwdata[CH_FIRST +: CHW];
   wire [CHW-1:0] c_last = pwdata[CH_LAST +: CHW];
   wire chcfg_bad = pwdata[CH_SETCNT] & ((c_cnt < CNT_MIN) | (c_cnt > CNT_MAX));
   logic [NCH-1:0] ch_match;
   logic ch_conf;
   // a single mismatched channel in the list rejects the whole setting
   always_comb begin
      ch_conf = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         ch_match[i] = ch_vld_r[i] & (ch_code_r[i] >= c_first) & (ch_code_r[i] <= c_last); // RULE7
         if (ch_match[i] && ch_func_r[i] != cfg_fn)
            ch_conf = 1'b1; // RULE8
      end
   end
   wire conf_ev = wr & hit_chcfg & ch_conf;
   wire chcfg_ok = wr & hit_chcfg & ~ch_conf & ~chcfg_bad;
   wire perr_ev = wr & ((hit_fcfg & fcfg_bad) | (hit_chcfg & chcfg_bad));
   wire [IW-1:0] d_idx = pwdata[CD_IDX +: IW];
   ////////////////////////////////////////////////////////////////////////////
   // reading path
   wire [FW-1:0] fn = fn_norm(rd_func); // RULE10
   logic ch_hit;
   logic [IW-1:0] ch_idx;
   always_comb begin
      ch_hit = 1'b0;
      ch_idx = '0;
      for (int i = 0; i < NCH; i++) begin
         if (scan_r && ch_vld_r[i] && ch_code_r[i] == slot_channel_code && ch_func_r[i] == fn) begin
            ch_hit = 1'b1;
            ch_idx = IW'(i);
         end
      end
   end
   wire raw_en = ch_hit ? ch_en_r[ch_idx] : fen_r[fn]; // RULE9
   wire [CW-1:0] eff_cnt = ch_hit ? ch_cnt_r[ch_idx] : fcnt_r[fn]; // RULE9
   wire eff_type = ftype_r[fn]; // RULE1
   wire eff_en = raw_en & ~(scan_r & eff_type == TYPE_SLIDE); // RULE17
   wire win_on = ~scan_r & (fwin_r[fn] != '0); // RULE3 RULE17
   wire restart = (fn != last_fn_r) | (rd_range != last_rng_r) | (fill_r > eff_cnt); // RULE18
   wire [CW-1:0] fill_b = restart ? '0 : fill_r;
   wire signed [SW-1:0] sum_b = restart ? '0 : sum_r;
   wire [CW-1:0] wp_b = restart ? '0 : wp_r;
   wire [DW-1:0] lim = range_limit(rd_range);
   wire signed [DW-1:0] cur_avg = avg_of(sum_b, fill_b);
   wire outside = win_on & (fill_b != '0) & win_out(rd_data, cur_avg, fwin_r[fn], lim);
   wire seed = eff_en & outside;
   wire over = abs_v(rd_data) > lim; // RULE14
   wire [CW-1:0] wp_inc = (CW'(wp_b + 7'h01) >= eff_cnt) ? '0 : CW'(wp_b + 7'h01);
   wire signed [SW-1:0] sum_add = sum_b + SW'(rd_data);
   wire [CW-1:0] fill_inc = CW'(fill_b + 7'h01);
   logic emit, push;
   logic signed [DW-1:0] avg_o;
   always_comb begin
      emit = 1'b0;
      push = 1'b0;
      sum_nxt = sum_r;
      fill_nxt = fill_r;
      wp_nxt = wp_r;
      avg_o = rd_data;
      if (rd_valid) begin
         emit = 1'b1;
         if (!eff_en) begin
            sum_nxt = '0;
            fill_nxt = '0;
            wp_nxt = '0;
         end else if (seed && eff_type == TYPE_SLIDE) begin
            sum_nxt = SW'(rd_data) * $signed({{(SW-CW){1'b0}}, eff_cnt}); // RULE16
            fill_nxt = eff_cnt;
            wp_nxt = '0;
         end else if (seed) begin
            sum_nxt = SW'(rd_data); // RULE16
            fill_nxt = CNT_MIN;
            wp_nxt = '0;
         end else if (eff_type == TYPE_SLIDE) begin
            push = 1'b1;
            wp_nxt = wp_inc;
            if (fill_b < eff_cnt) begin
               sum_nxt = sum_add;
               fill_nxt = fill_inc;
            end else begin
               sum_nxt = sum_add - SW'(stk_r[wp_b]); // RULE15
               fill_nxt = fill_b;
            end
            avg_o = avg_of(sum_nxt, fill_nxt);
         end else begin
            // block averaging emits only on a full stack, then starts over
            sum_nxt = sum_add;
            fill_nxt = fill_inc;
            emit = (fill_inc == eff_cnt); // RULE15
            avg_o = avg_of(sum_add, fill_inc);
            if (fill_inc == eff_cnt) begin
               sum_nxt = '0;
               fill_nxt = '0;
            end
         end
      end
   end
   wire cap = emit & rel_cap_r[fn]; // RULE11
   wire signed [DW-1:0] ref_use = cap ? avg_o : ref_r[fn]; // RULE12
   wire signed [OW-1:0] rel_diff = rel_en_r[fn] ? OW'(avg_o) - OW'(ref_use) : OW'(avg_o); // RULE19
   wire settled = ~eff_en | (fill_nxt == eff_cnt) | (eff_type == TYPE_BLOCK & emit);
   wire [NST-1:0] ev = {perr_ev, emit & over, conf_ev, emit};
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ftype_r <= {NF{TYPE_BLOCK}}; // RULE5
         fen_r <= '0; // RULE6
         rel_en_r <= '0;
         rel_cap_r <= '0;
         for (int i = 0; i < NF; i++) begin
            fcnt_r[i] <= CNT_DEF; // RULE4
            fwin_r[i] <= WIN_DEF; // RULE2
            ref_r[i] <= '0;
         end
      end else if (preset_w) begin
         ftype_r <= {NF{TYPE_SLIDE}}; // RULE5
         fen_r <= '1; // RULE6
         for (int i = 0; i < NF; i++) begin
            fcnt_r[i] <= CNT_DEF;
            fwin_r[i] <= WIN_DEF;
         end
      end else begin
         if (cap)
            ref_r[fn] <= avg_o; // RULE11 RULE13
         if (cap)
            rel_cap_r[fn] <= 1'b0;
         if (fcfg_ok) begin
            ftype_r[cfg_fn] <= pwdata[FC_TYPE]; // RULE1
            fen_r[cfg_fn] <= pwdata[FC_EN];
            fcnt_r[cfg_fn] <= w_cnt;
            fwin_r[cfg_fn] <= w_win; // RULE3
            rel_en_r[cfg_fn] <= pwdata[FC_REL];
            if (pwdata[FC_REL] && !rel_en_r[cfg_fn])
               rel_cap_r[cfg_fn] <= 1'b1; // RULE11
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_vld_r <= '0;
         ch_en_r <= '0;
         for (int i = 0; i < NCH; i++) begin
            ch_code_r[i] <= '0;
            ch_func_r[i] <= '0;
            ch_cnt_r[i] <= CNT_DEF;
         end
      end else if (wr && hit_chdef) begin
         ch_code_r[d_idx] <= pwdata[CD_CODE +: CHW]; // RULE7
         ch_func_r[d_idx] <= fn_norm(pwdata[CD_FUNC +: FW]);
         ch_vld_r[d_idx] <= pwdata[CD_VALID];
      end else if (chcfg_ok) begin
         for (int i = 0; i < NCH; i++) begin
            if (ch_match[i] && pwdata[CH_SETCNT])
               ch_cnt_r[i] <= c_cnt; // RULE9
            if (ch_match[i] && pwdata[CH_SETEN])
               ch_en_r[i] <= pwdata[CH_EN]; // RULE9
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < STK; i++)
            stk_r[i] <= '0;
      end else if (rd_valid && seed) begin
         for (int i = 0; i < STK; i++)
            stk_r[i] <= rd_data; // RULE16
      end else if (push) begin
         stk_r[wp_b] <= rd_data; // RULE15
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sum_r <= '0;
         fill_r <= '0;
         wp_r <= '0;
         last_fn_r <= '0;
         last_rng_r <= '0;
      end else begin
         sum_r <= sum_nxt;
         fill_r <= fill_nxt;
         wp_r <= wp_nxt;
         if (rd_valid) begin
            last_fn_r <= fn; // RULE18
            last_rng_r <= rd_range;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_data <= '0;
         out_over <= 1'b0;
         out_settled <= 1'b1;
         last_r <= '0;
      end else begin
         out_valid <= emit;
         if (emit) begin
            out_data <= rel_diff; // RULE11
            out_over <= over; // RULE14
            last_r <= avg_o;
         end
         if (rd_valid)
            out_settled <= settled;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // read-clear drops only bits already reported, so a new event survives
   logic [31:0] rd_mux;
   always_comb begin
      if (hit_ctrl)
         rd_mux = 32'(scan_r) << CT_SCAN;
      else if (hit_fsel)
         rd_mux = 32'(fsel_r);
      else if (hit_fcfg)
         rd_mux = (32'(ftype_r[cfg_fn]) << FC_TYPE) | (32'(fen_r[cfg_fn]) << FC_EN) |
                  (32'(rel_en_r[cfg_fn]) << FC_REL) | (32'(fcnt_r[cfg_fn]) << FC_CNT) |
                  (32'(fwin_r[cfg_fn]) << FC_WIN);
      else if (hit_stat)
         rd_mux = 32'(st_r);
      else if (hit_mask)
         rd_mux = 32'(mask_r);
      else if (hit_err)
         rd_mux = err_r;
      else if (hit_ref)
         rd_mux = 32'(ref_r[cfg_fn]);
      else if (hit_last)
         rd_mux = 32'(last_r);
      else
         rd_mux = '0;
   end
   wire stat_clr = acc_rd & hit_stat;
   wire err_clr = acc_rd & hit_err;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= '0;
         st_r <= '0;
         mask_r <= '0;
         err_r <= '0;
         fsel_r <= '0;
         scan_r <= 1'b0;
      end else begin
         if (setup_rd)
            rdata_r <= rd_mux;
         st_r <= (stat_clr ? st_r & ~rdata_r[NST-1:0] : st_r) | ev;
         if (conf_ev)
            err_r <= ERR_CONFLICT; // RULE8
         else if (err_clr)
            err_r <= '0;
         if (wr && hit_mask)
            mask_r <= pwdata[NST-1:0];
         if (wr && hit_fsel)
            fsel_r <= pwdata[FW-1:0];
         if (wr && hit_ctrl)
            scan_r <= pwdata[CT_SCAN];
      end
   end
   assign pready = 1'b1;
   assign prdata = acc_rd ? rdata_r : '0;
   assign pslverr = psel & penable & ~mapped;
   assign irq = |(st_r & mask_r);
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   preset_type_a: assert property (preset_w |=> &ftype_r) // RULE5
      else $error("preset did not select sliding type");
   preset_en_a: assert property (preset_w |=> &fen_r) // RULE6
      else $error("preset did not enable filter");
   win_range_a: assert property (fwin_r[cfg_fn] <= WIN_MAX) // RULE2
      else $error("window beyond ten percent");
   cnt_range_a: assert property (fcnt_r[cfg_fn] >= CNT_MIN && fcnt_r[cfg_fn] <= CNT_MAX) // RULE4
      else $error("count outside 1..100");
   conflict_err_a: assert property (conf_ev |=> err_r == ERR_CONFLICT && st_r[ST_CONF]) // RULE8
      else $error("conflict not reported as -221");
   rel_zero_a: assert property (cap && rel_en_r[fn] |=> out_data == '0) // RULE11
      else $error("captured reference does not zero output");
   over_raw_a: assert property (rd_valid && emit && !over |=> !out_over) // RULE14
      else $error("overflow without raw input beyond range");
   scan_slide_a: assert property (rd_valid && scan_r && eff_type == TYPE_SLIDE &&
                                  !rel_en_r[fn] |=> out_valid && out_data == OW'($past(rd_data))) // RULE17
      else $error("sliding filter active during scan");
   win_off_a: assert property (rd_valid && fwin_r[fn] == '0 |-> !seed) // RULE3
      else $error("restart with window off");
   fn_change_a: assert property (rd_valid && fn != last_fn_r |=> fill_r <= CNT_MIN) // RULE18
      else $error("filter not reset on function change");
   slide_full_a: assert property (rd_valid && eff_en && eff_type == TYPE_SLIDE && !seed &&
                                  fill_b == eff_cnt |=> fill_r == $past(eff_cnt)) // RULE15
      else $error("sliding stack depth changed");
   cover_seed_c: cover property (rd_valid && seed);
   cover_block_c: cover property (emit && eff_en && eff_type == TYPE_BLOCK);
   cover_conf_c: cover property (conf_ev);
   cover_cap_c: cover property (cap ##1 out_valid);
endmodule

// [rfr_adc_model.sv]
// behavioural a/d side that hands readings to the filter block
`timescale 1ns/100ps
module rfr_adc_model
   import rfr_pkg::*;
(
   input wire logic pclk,
   output logic rd_valid,
   output logic signed [DW-1:0] rd_data,
   output logic [FW-1:0] rd_func,
   output logic [2:0] rd_range,
   output logic [CHW-1:0] slot_channel_code
);
   initial begin
      rd_valid = 1'b0;
      rd_data = '0;
      rd_func = 3'h0;
      rd_range = 3'h7;
      slot_channel_code = 10'h065;
   end
   ////////////////////////////////////////////////////////////////
   // one reading per call; gap lets the source run slow
   task automatic send(input logic signed [DW-1:0] d, input logic [2:0] r, input int gap);
      @(posedge pclk);
      rd_valid <= 1'b1;
      rd_data <= d;
      rd_range <= r;
      @(posedge pclk);
      rd_valid <= 1'b0;
      // idle bus shows the inverse so a stale reading is never mistaken
      rd_data <= ~d;
      repeat (gap) @(posedge pclk);
   endtask
   // function of the readings that follow; changed only between readings
   task automatic set_func(input logic [FW-1:0] f);
      @(posedge pclk);
      rd_func <= f;
   endtask
endmodule

// [testbench.sv]
// self-checking bench for the reading filter and relative block
`timescale 1ns/100ps
module testbench;
   import rfr_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = '0;
   logic pready, pslverr, irq, rd_valid, out_valid, out_over, out_settled, er;
   logic [31:0] prdata, q;
   logic signed [DW-1:0] rd_data;
   logic [FW-1:0] rd_func;
   logic [2:0] rd_range;
   logic [CHW-1:0] slot_channel_code;
   logic signed [OW-1:0] out_data;
   logic [OW:0] exp_q[$];
   int fail_count = 0;
   int num_checks = 0;
   rfr_filter uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .irq(irq), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_func(rd_func), .rd_range(rd_range),
      .slot_channel_code(slot_channel_code), .out_valid(out_valid),
      .out_data(out_data), .out_over(out_over), .out_settled(out_settled));
   rfr_adc_model adc (.pclk(pclk), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_func(rd_func), .rd_range(rd_range), .slot_channel_code(slot_channel_code));
   initial begin
      forever #10 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("prdata", e, q);
   endtask
   // note the expected output first, then let the source send the reading
   task automatic rd(input logic signed [DW-1:0] d, input logic [2:0] r, input logic emit,
      input logic signed [OW-1:0] e, input logic o, input logic s);
      if (emit) exp_q.push_back({o, e});
      adc.send(d, r, 0);
      // settled level is launched at the reading edge; look half a cycle later
      @(negedge pclk);
      chk("out_settled", 32'(s), 32'(out_settled));
   endtask
   always @(posedge pclk) begin
      if (out_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("out_extra", 32'h0, 32'h1);
         else chk("out", 32'(exp_q.pop_front()), 32'({out_over, out_data}));
      end
   end
   initial begin
      #400000;
      fail_count++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      logic signed [DW-1:0] v;
      void'($urandom(32'hE5EA5BD2));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdr(A_FCFG, 32'h000A0A00);
      for (int i = 0; i < 8; i++) begin
         v = $urandom_range(2 * TOP_LIMIT) - TOP_LIMIT;
         rd(v, 3'h7, 1'b1, OW'(v), 1'b0, 1'b1);
      end
      apb(1'b1, A_FCFG, 32'h00000202);
      rd(24'sh64, 3'h7, 1'b0, 25'sh0, 1'b0, 1'b0);
      rd(24'sh12C, 3'h7, 1'b1, 25'shC8, 1'b0, 1'b1);
      rd(24'shA, 3'h7, 1'b0, 25'sh0, 1'b0, 1'b0);
      rd(24'sh1E, 3'h7, 1'b1, 25'sh14, 1'b0, 1'b1);
      apb(1'b1, A_FCFG, 32'h00000102);
      rd(24'sh4D, 3'h7, 1'b1, 25'sh4D, 1'b0, 1'b1);
      apb(1'b1, A_FCFG, 32'h00000203);
      rd(24'sh64, 3'h7, 1'b1, 25'sh64, 1'b0, 1'b0);
      rd(24'sh64, 3'h7, 1'b1, 25'sh64, 1'b0, 1'b1);
      rd(24'sh12C, 3'h7, 1'b1, 25'shC8, 1'b0, 1'b1);
      rd(24'sh1F4, 3'h7, 1'b1, 25'sh190, 1'b0, 1'b1);
      rd(24'shF4240, 3'h7, 1'b1, 25'sh7A21A, 1'b0, 1'b1);
      apb(1'b1, A_FCFG, 32'h03E80203);
      rd(24'shF4240, 3'h7, 1'b1, 25'shF4240, 1'b0, 1'b1);
      rd(24'sh4C4B40, 3'h7, 1'b1, 25'sh4C4B40, 1'b0, 1'b1);
      apb(1'b1, A_CTRL, 32'h00000002);
      rd(24'sh4C4B42, 3'h7, 1'b1, 25'sh4C4B42, 1'b0, 1'b1);
      apb(1'b1, A_CTRL, 32'h00000000);
      apb(1'b1, A_FCFG, 32'h00000A04);
      rd(24'sh6ACFC0, 3'h7, 1'b1, 25'sh0, 1'b0, 1'b1);
      rdr(A_REF, 32'h006ACFC0);
      rd(24'shDBBA0, 3'h6, 1'b1, -25'sh5D1420, 1'b0, 1'b1);
      rd(24'sh124F80, 3'h6, 1'b1, -25'sh588040, 1'b1, 1'b1);
      rd(-24'sh7A1200, 3'h7, 1'b1, -25'shE4E1C0, 1'b0, 1'b1);
      apb(1'b0, A_STAT, 32'h0);
      apb(1'b1, A_MASK, 32'h00000008);
      apb(1'b1, A_FCFG, 32'h00006503);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h1, 32'(irq));
      rdr(A_STAT, 32'h00000008);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, 32'(irq));
      apb(1'b1, A_FCFG, 32'h03E90A03);
      rdr(A_FCFG, 32'h00000A04);
      apb(1'b1, A_MASK, 32'h00000000);
      apb(1'b1, A_FCFG, 32'h00000002);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, 32'(irq));
      rdr(A_STAT, 32'h00000008);
      apb(1'b1, A_FSEL, 32'h00000006);
      apb(1'b1, A_FCFG, 32'h00140A01);
      apb(1'b1, A_FSEL, 32'h00000000);
      rdr(A_FCFG, 32'h00140A01);
      apb(1'b1, A_CTRL, 32'h00000001);
      rdr(A_FCFG, 32'h000A0A03);
      apb(1'b1, A_FSEL, 32'h00000005);
      rdr(A_FCFG, 32'h000A0A03);
      apb(1'b1, A_FSEL, 32'h00000000);
      apb(1'b1, A_CHDEF, 32'h00024650);
      apb(1'b1, A_CTRL, 32'h00000002);
      apb(1'b1, A_CHCFG, 32'h10519465);
      rdr(A_ERR, ERR_CONFLICT);
      rdr(A_STAT, 32'h00000002);
      rdr(A_ERR, 32'h0);
      // per-channel count 2 on a dc alias reading; range change restarts the block
      apb(1'b1, A_FSEL, 32'h00000001);
      apb(1'b1, A_FCFG, 32'h000A0A02);
      apb(1'b1, A_CHCFG, 32'h38219465);
      adc.set_func(3'h7);
      rd(24'shA, 3'h7, 1'b0, 25'sh0, 1'b0, 1'b0);
      rd(24'sh1E, 3'h6, 1'b0, 25'sh0, 1'b0, 1'b0);
      rd(24'sh32, 3'h6, 1'b1, 25'sh28, 1'b0, 1'b1);
      apb(1'b0, 8'h40, 32'h0);
      chk("pslverr", 32'h1, 32'(er));
      repeat (4) @(posedge pclk);
      chk("pending", 32'h0, 32'(exp_q.size()));
      // second reset in mid-run must undo the preset defaults
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rdr(A_FCFG, 32'h000A0A00);
      complete_run();
   end
endmodule
